// file: hdl/scl_loader.v
// Overview of operation
// (RULE1) Load vectors from serial memory after reset
// (RULE2) Partner supplies start and end markers
// (RULE3) Failed or badly framed load keeps defaults
// (RULE4) Data moves as eight-bit words
// (RULE5) Partner streams everything after one select
// (RULE6) Device drives the configuration clock
// (RULE7) Only begin and finish commands issued
// (RULE8) Low reset pin acts at any time
// (RULE9) Reset pin held low four reference cycles
// (RULE10) Reset: parallel outputs low, serial high
// (RULE11) Reset: configuration data pin released
// (RULE12) Report upstream sync loss when enabled
// (RULE13) Fault output behaviour chosen by vector field
// (RULE14) Core clock from PLL locked to reference
// (RULE15) Apply loaded vectors only after clean frame
`timescale 1ns/10ps
`include "scl_consts.vh"
module scl_loader
(
   // Core clock and reset
   input  wire                   core_clk,
   input  wire                   srst,
   // Device pins: reset, PLL status
   input  wire                   ext_rst_n,
   input  wire                   pll_locked,
   // Configuration interface
   output wire                   cfg_clk_out,
   input  wire                   cfg_data_in,
   output wire                   cfg_data_out,
   output wire                   cfg_data_oe,
   // Vector consumer
   input  wire                   consumer_busy,
   output wire [`SCL_VEC_W-1:0]  cfg_vec,
   output wire                   load_done,
   output wire                   load_ok,
   // Downstream serial pads
   input  wire                   ser_p_src,
   input  wire                   ser_n_src,
   output wire                   downstream_serial_out_p,
   output wire                   downstream_serial_out_n,
   // Upstream link status
   input  wire                   link_sync_ok,
   output wire                   link_fault_out
);

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam ST_WAIT = 3'h0;
   localparam ST_CMD  = 3'h1;
   localparam ST_RX   = 3'h2;
   localparam ST_FIN  = 3'h3;
   localparam ST_END  = 3'h4;
   localparam [`SCL_DIV_W-1:0] HALF_LAST = `SCL_HALF_LAST;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   reg  [`SCL_SYNC_W-1:0] s1_r;
   reg  [`SCL_SYNC_W-1:0] s2_r;
   reg  [`SCL_SYNC_W-1:0] s3_r;
   reg  [`SCL_SYNC_W-1:0] filt_r;
   wire [`SCL_SYNC_W-1:0] filt_nxt;
   wire [`SCL_SYNC_W-1:0] agree;

   // Change accepted only once stages two and three agree
   assign agree    = ~(s2_r ^ s3_r);
   assign filt_nxt = (agree & s3_r) | (~agree & filt_r);

   always @(posedge core_clk)
   begin
      if (srst)
      begin
         s1_r   <= `SCL_SYNC_INIT;
         s2_r   <= `SCL_SYNC_INIT;
         s3_r   <= `SCL_SYNC_INIT;
         filt_r <= `SCL_SYNC_INIT;
      end
      else
      begin
         s1_r   <= {pll_locked, link_sync_ok, ext_rst_n, cfg_data_in};
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         filt_r <= filt_nxt;
      end
   end

   wire din_f  = filt_r[`SCL_LN_DATA];
   wire lock_f = filt_r[`SCL_LN_LOCK];
   wire sync_f = filt_r[`SCL_LN_SYNC];
   // Short pin pulses may be missed by the filter; hold low long enough
   wire rst    = srst | ~filt_r[`SCL_LN_RSTN];        // [RULE8] [RULE9]
   // Raw pin gates the pads so they act without waiting for a clock
   wire hold   = rst | ~ext_rst_n;                    // [RULE8]

   // ----------------------------------------------------------------
   // Serial engine
   // ----------------------------------------------------------------
   reg  [2:0]                st_r;
   reg  [`SCL_DIV_W-1:0]     div_r;
   reg                       sck_r;
   reg                       oe_r;
   reg  [`SCL_WORD_W-1:0]    tx_sh_r;
   reg  [`SCL_WORD_W-1:0]    rx_sh_r;
   reg  [2:0]                bit_r;
   reg  [3:0]                byte_r;
   reg                       pend_r;
   reg  [`SCL_WORD_W-1:0]    push_data_r;
   wire                      fifo_in_ready;
   wire                      running;
   wire                      stall;
   wire                      tick;
   wire                      fall;

   assign running = (st_r == ST_CMD) | (st_r == ST_RX) | (st_r == ST_FIN);
   // Full buffer freezes the clock low until a slot frees
   assign stall   = pend_r & ~fifo_in_ready;
   assign tick    = running & ~stall & (div_r == HALF_LAST);
   assign fall    = tick & sck_r;

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         st_r    <= ST_WAIT;
         div_r   <= {`SCL_DIV_W{1'b0}};
         sck_r   <= 1'b0;
         oe_r    <= 1'b0;
         tx_sh_r <= {`SCL_WORD_W{1'b0}};
         rx_sh_r <= {`SCL_WORD_W{1'b0}};
         bit_r   <= 3'h0;
         byte_r  <= 4'h0;
         pend_r  <= 1'b0;
         push_data_r <= {`SCL_WORD_W{1'b0}};
      end
      else
      begin
         if (pend_r && fifo_in_ready)
         begin
            pend_r <= 1'b0;
         end
         if (running && !stall)
         begin
            div_r <= tick ? {`SCL_DIV_W{1'b0}} : div_r + 1'b1;
         end
         if (tick)
         begin
            sck_r <= ~sck_r;                          // [RULE6]
         end
         case (st_r)
            ST_WAIT:
            begin
               // Wait for a stable core clock before clocking out
               if (lock_f)                            // [RULE14]
               begin
                  st_r    <= ST_CMD;                  // [RULE1]
                  tx_sh_r <= `SCL_BEGIN_CMD;          // [RULE7]
                  oe_r    <= 1'b1;
                  div_r   <= {`SCL_DIV_W{1'b0}};
               end
            end
            ST_CMD, ST_FIN:
            begin
               if (fall)
               begin
                  tx_sh_r <= {tx_sh_r[`SCL_WORD_W-2:0], 1'b0};
                  bit_r   <= bit_r + 1'b1;
                  if (bit_r == 3'h7)
                  begin
                     st_r <= (st_r == ST_CMD) ? ST_RX : ST_END;
                     oe_r <= 1'b0;
                  end
               end
            end
            ST_RX:
            begin
               // One select, then the whole frame streams in
               if (fall)                              // [RULE5]
               begin
                  rx_sh_r <= {rx_sh_r[`SCL_WORD_W-2:0], din_f};
                  bit_r   <= bit_r + 1'b1;
                  if (bit_r == 3'h7)                  // [RULE4]
                  begin
                     pend_r <= 1'b1;
                     push_data_r <= {rx_sh_r[`SCL_WORD_W-2:0], din_f};
                     byte_r <= byte_r + 1'b1;
                     if (byte_r == `SCL_LAST_IDX)
                     begin
                        st_r    <= ST_FIN;
                        tx_sh_r <= `SCL_FINISH_CMD;   // [RULE7]
                        oe_r    <= 1'b1;
                     end
                  end
               end
            end
            ST_END:  st_r <= ST_END;
            default: st_r <= ST_WAIT;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Byte buffer
   // ----------------------------------------------------------------
   wire                   fifo_out_valid;
   wire                   fifo_out_ready;
   wire [`SCL_WORD_W-1:0] fifo_out_data;

   scl_fifo
   #(
      .WIDTH (`SCL_WORD_W),
      .DEPTH (`SCL_FIFO_DEPTH),
      .AW    (`SCL_FIFO_AW)
   )
   u_fifo
   (
      .core_clk  (core_clk),
      .srst      (rst),
      .in_valid  (pend_r),
      .in_ready  (fifo_in_ready),
      .in_data   (push_data_r),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // ----------------------------------------------------------------
   // Frame check and vector store
   // ----------------------------------------------------------------
   reg  [`SCL_WORD_W-1:0] shadow [0:`SCL_VEC_BYTES-1];
   reg  [3:0]             idx_r;
   reg                    start_ok_r;
   reg                    done_r;
   reg                    ok_r;
   reg  [`SCL_VEC_W-1:0]  vec_r;
   wire                   pop;
   integer                i;

   assign fifo_out_ready = ~consumer_busy & ~done_r;
   assign pop            = fifo_out_valid & fifo_out_ready;

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         idx_r      <= 4'h0;
         start_ok_r <= 1'b0;
         done_r     <= 1'b0;
         ok_r       <= 1'b0;
         vec_r      <= `SCL_DEFAULT_VEC;              // [RULE3]
      end
      else if (pop)
      begin
         idx_r <= idx_r + 1'b1;
         if (idx_r != 4'h0 && idx_r != `SCL_LAST_IDX)
         begin
            shadow[idx_r[2:0] - 3'h1] <= fifo_out_data;
         end
         if (idx_r == 4'h0)
         begin
            start_ok_r <= (fifo_out_data == `SCL_START_MARK); // [RULE2]
         end
         if (idx_r == `SCL_LAST_IDX)
         begin
            done_r <= 1'b1;
            // Bad marker on either end leaves the defaults standing
            if (start_ok_r && fifo_out_data == `SCL_END_MARK) // [RULE3]
            begin
               ok_r <= 1'b1;
               for (i = 0; i < `SCL_VEC_BYTES; i = i + 1)
               begin
                  vec_r[i*`SCL_WORD_W +: `SCL_WORD_W] <= shadow[i]; // [RULE15]
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Link fault reporting
   // ----------------------------------------------------------------
   reg        fault_r;
   reg        sticky_r;
   reg        fault_nxt;
   wire [1:0] flt_mode = vec_r[`SCL_FLT_MODE_LSB +: 2];
   wire       up_en    = vec_r[`SCL_UP_EN_BIT];
   wire       lost     = up_en & ~sync_f;             // [RULE12]

   always @*
   begin
      case (flt_mode)                                 // [RULE13]
         `SCL_FLT_HIGH:   fault_nxt = lost;
         `SCL_FLT_LOW:    fault_nxt = ~lost;
         `SCL_FLT_STICKY: fault_nxt = sticky_r | lost;
         `SCL_FLT_OFF:    fault_nxt = 1'b0;
         default:         fault_nxt = 1'b0;
      endcase
   end

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         fault_r  <= 1'b0;
         sticky_r <= 1'b0;
      end
      else
      begin
         fault_r <= fault_nxt;
         // Latched loss clears only through reset
         if (lost && flt_mode == `SCL_FLT_STICKY)
         begin
            sticky_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pad drive
   // ----------------------------------------------------------------
   assign cfg_clk_out    = sck_r & ~hold;             // [RULE10]
   assign cfg_data_out   = tx_sh_r[`SCL_WORD_W-1] & ~hold;
   assign cfg_data_oe    = oe_r & ~hold;              // [RULE11]
   assign link_fault_out = fault_r & ~hold;           // [RULE10]
   assign downstream_serial_out_p = hold | ser_p_src; // [RULE10]
   assign downstream_serial_out_n = hold | ser_n_src; // [RULE10]
   assign cfg_vec        = vec_r;
   assign load_done      = done_r & ~hold;
   assign load_ok        = ok_r & ~hold;

endmodule

// file: shared/scl_consts.vh
`ifndef SCL_CONSTS_VH
`define SCL_CONSTS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCL_CORE_PERIOD_NS 10
`define SCL_CLK_HALF_NS    200
// Half link period less one, in core cycles
`define SCL_HALF_LAST      8'h13
`define SCL_DIV_W          8

// ----------------------------------------------------------------
// Word layout and load frame
// ----------------------------------------------------------------
`define SCL_WORD_W         8
`define SCL_VEC_BYTES      8
`define SCL_VEC_W          64
`define SCL_FRAME_BYTES    4'hA
`define SCL_LAST_IDX       4'h9
`define SCL_FIFO_DEPTH     32
`define SCL_FIFO_AW        5

// ----------------------------------------------------------------
// Command and marker bytes
// ----------------------------------------------------------------
`define SCL_BEGIN_CMD      8'hC0
`define SCL_FINISH_CMD     8'h80
`define SCL_START_MARK     8'hA5
`define SCL_END_MARK       8'h5A

// ----------------------------------------------------------------
// Built-in defaults and vector fields
// ----------------------------------------------------------------
`define SCL_DEFAULT_VEC    64'h0000_0000_0000_0000
`define SCL_UP_EN_BIT      0
`define SCL_FLT_MODE_LSB   1
`define SCL_FLT_HIGH       2'h0
`define SCL_FLT_LOW        2'h1
`define SCL_FLT_STICKY     2'h2
`define SCL_FLT_OFF        2'h3

// ----------------------------------------------------------------
// Pin synchroniser lanes: data, reset pin, link sync, pll lock
// ----------------------------------------------------------------
`define SCL_SYNC_W         4
`define SCL_SYNC_INIT      4'h2
`define SCL_LN_DATA        0
`define SCL_LN_RSTN        1
`define SCL_LN_SYNC        2
`define SCL_LN_LOCK        3

`endif

// file: hdl/scl_fifo.v
`timescale 1ns/10ps
module scl_fifo
#(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW    = 5
)
(
   // Clock and reset
   input  wire             core_clk,
   input  wire             srst,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr_r;
   reg  [AW-1:0]    rd_ptr_r;
   reg  [AW:0]      count_r;
   wire             push;
   wire             pop;

   assign in_ready  = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge core_clk)
   begin
      if (push)
      begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always @(posedge core_clk)
   begin
      if (srst)
      begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop)
         begin
            count_r <= count_r + 1'b1;
         end
         else if (pop && !push)
         begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule

// file: verification/scl_loader_assertions.sv
`timescale 1ns/10ps
`include "scl_consts.vh"
module scl_loader_chk
(
   // Clock, resets, lock
   input wire                  core_clk,
   input wire                  srst,
   input wire                  ext_rst_n,
   input wire                  pll_locked,
   // Config link
   input wire                  cfg_clk_out,
   input wire                  cfg_data_in,
   input wire                  cfg_data_out,
   input wire                  cfg_data_oe,
   // Vectors
   input wire                  consumer_busy,
   input wire [`SCL_VEC_W-1:0] cfg_vec,
   input wire                  load_done,
   input wire                  load_ok,
   // Pads and link status
   input wire                  ser_p_src,
   input wire                  ser_n_src,
   input wire                  downstream_serial_out_p,
   input wire                  downstream_serial_out_n,
   input wire                  link_sync_ok,
   input wire                  link_fault_out
);
   wire [1:0] md = cfg_vec[`SCL_FLT_MODE_LSB+:2];
   wire       en = cfg_vec[`SCL_UP_EN_BIT];
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst || !ext_rst_n);
   // ------
   // Pin reset acts without the clock, so no disable here
   // ------
   a_rst_data_off: assert property (disable iff (1'b0)
      !ext_rst_n |-> !cfg_data_oe) else $error("data pin driven in reset");
   a_rst_pads_set: assert property (disable iff (1'b0)
      !ext_rst_n |-> downstream_serial_out_p && downstream_serial_out_n
      && !link_fault_out && !load_done) else $error("pads wrong in reset");
   a_rst_clk_held: assert property (disable iff (1'b0)
      !ext_rst_n |-> !cfg_clk_out && !load_ok)
      else $error("clock or ok active in reset");
   a_clk_high_len: assert property (
      $rose(cfg_clk_out) |-> cfg_clk_out[*8] ##13 !cfg_clk_out)
      else $error("link clock high phase wrong");
   a_data_hold_hi: assert property (
      cfg_clk_out |-> $stable(cfg_data_out))
      else $error("data moved while clock high");
   a_fail_dflt_kept: assert property (
      load_done && !load_ok |-> cfg_vec == `SCL_DEFAULT_VEC)
      else $error("failed load changed vectors");
   a_vec_only_ok: assert property (
      !$rose(load_ok) |-> $stable(cfg_vec))
      else $error("vectors changed without good load");
   a_ok_has_done: assert property (
      load_ok |-> load_done) else $error("ok without done");
   a_fault_off_low: assert property (
      (md == `SCL_FLT_OFF)[*8] |-> !link_fault_out)
      else $error("fault out active in off mode");
   a_fault_loss_hi: assert property (
      (en && md == `SCL_FLT_HIGH && !link_sync_ok)[*8] |-> link_fault_out)
      else $error("sync loss not reported");
   a_fault_inv_hi: assert property (
      (md == `SCL_FLT_LOW && (!en || link_sync_ok))[*8] |-> link_fault_out)
      else $error("inverted fault output wrong");
   a_sticky_hold: assert property (
      md == `SCL_FLT_STICKY && $past(link_fault_out) |-> link_fault_out)
      else $error("sticky fault cleared");
endmodule

// file: verification/scl_prom_model.sv
`timescale 1ns/10ps
`include "scl_consts.vh"
module scl_prom_model
(
   // Link side
   input wire        cfg_clk_out,
   input wire        rst,
   input wire        cfg_data_oe,
   input wire        cfg_data_out,
   // Bench side
   input wire [79:0] frame,
   output reg        sdo,
   output reg [15:0] cmd_log
);
   reg [6:0] sh;
   reg [2:0] nb;
   reg       rd;
   integer   k;
   initial sdo = 1'b0;
   // ------
   // Shift on the rising device clock, hold through the fall
   // ------
   always @(posedge cfg_clk_out or posedge rst)
      if (rst)
      begin
         sh <= 7'h00;
         nb <= 3'h0;
         rd <= 1'b0;
         k <= 0;
         cmd_log <= 16'h0000;
      end
      else if (cfg_data_oe)
      begin
         sh <= {sh[5:0], cfg_data_out};
         nb <= nb + 3'h1;
         if (nb == 3'h7)
         begin
            cmd_log <= {cmd_log[7:0], sh, cfg_data_out};
            rd <= ({sh, cfg_data_out} == `SCL_BEGIN_CMD);
         end
      end
      else if (rd && k < 80)
      begin
         sdo <= frame[79-k];
         k <= k + 1;
      end
      else
         sdo <= ~sdo; // Wobbles so a stale bit never passes for data
endmodule

// file: verification/scl_loader_tb_top.sv
`timescale 1ns/10ps
`include "scl_consts.vh"
module scl_loader_tb_top;
   reg         core_clk = 1'b0;
   reg         srst = 1'b1;
   reg         ext_rst_n = 1'b1;
   reg         pll_locked = 1'b1;
   reg         consumer_busy = 1'b0;
   reg         ser_p_src = 1'b0;
   reg         ser_n_src = 1'b0;
   reg         link_sync_ok = 1'b1;
   reg  [79:0] frame = 80'h0;
   reg  [63:0] v;
   wire [63:0] cfg_vec;
   wire [15:0] cmd_log;
   wire        cfg_clk_out, cfg_data_out, cfg_data_oe, cfg_data_in, p_sdo;
   wire        load_done, load_ok, link_fault_out;
   wire        downstream_serial_out_p, downstream_serial_out_n;
   integer     errors, checks_done, i, n, sd;
   assign cfg_data_in = cfg_data_oe ? cfg_data_out : p_sdo;
   scl_loader dut_u
   (
      .core_clk, .srst, .ext_rst_n, .pll_locked, .cfg_clk_out,
      .cfg_data_in, .cfg_data_out, .cfg_data_oe, .consumer_busy,
      .cfg_vec, .load_done, .load_ok, .ser_p_src, .ser_n_src,
      .downstream_serial_out_p, .downstream_serial_out_n,
      .link_sync_ok, .link_fault_out
   );
   scl_prom_model prom_u
   (
      .cfg_clk_out, .rst(srst | ~ext_rst_n), .cfg_data_oe,
      .cfg_data_out, .frame, .sdo(p_sdo), .cmd_log
   );
   initial
      forever #5 core_clk = ~core_clk;
   always @(negedge core_clk)
      {ser_p_src, ser_n_src} <= 2'($urandom);
   // ------
   // Checks and expectations
   // ------
   task chk(input string nm, input [63:0] exp, input [63:0] got);
      begin
         checks_done = checks_done + 1;
         if (got !== exp)
         begin
            errors = errors + 1;
            $display("[FAIL] %0s exp %h got %h", nm, exp, got);
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d errors %0d", checks_done, errors);
         if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   function fexp(input [63:0] vv, input ph);
      reg e;
      begin
         e = vv[`SCL_UP_EN_BIT];
         case (vv[`SCL_FLT_MODE_LSB+:2])
            `SCL_FLT_HIGH: fexp = ph ? 1'b0 : e;
            `SCL_FLT_LOW: fexp = ph ? 1'b1 : ~e;
            `SCL_FLT_STICKY: fexp = e;
            default: fexp = 1'b0;
         endcase
      end
   endfunction
   function [79:0] mkf(input [63:0] vv, input [7:0] st, input [7:0] en);
      integer j;
      begin
         mkf = {st, 64'h0, en};
         for (j = 0; j < 8; j = j + 1)
            mkf[71-8*j-:8] = vv[8*j+:8];
      end
   endfunction
   // Mode 0 plain, 1 pin reset, 2 late lock, 3 consumer stalled
   task run(input [63:0] vv, input [7:0] st, input [7:0] en,
      input [1:0] md);
      reg        g;
      reg [63:0] ev;
      begin
         g = (st == `SCL_START_MARK) && (en == `SCL_END_MARK);
         ev = g ? vv : `SCL_DEFAULT_VEC;
         @(negedge core_clk);
         frame = mkf(vv, st, en);
         consumer_busy = (md == 2'h3);
         pll_locked = (md != 2'h2);
         if (md == 2'h1)
         begin
            ext_rst_n = 1'b0;
            #1;
            chk("pads_rst", 8'h03,
               {cfg_clk_out, cfg_data_oe, cfg_data_out, link_fault_out,
               load_done, load_ok, downstream_serial_out_p,
               downstream_serial_out_n});
            repeat (40) @(negedge core_clk);
            chk("vec_rst", `SCL_DEFAULT_VEC, cfg_vec);
            ext_rst_n = 1'b1;
         end
         else
         begin
            srst = 1'b1;
            repeat (2) @(negedge core_clk);
            srst = 1'b0;
         end
         if (md == 2'h2)
         begin
            repeat (300) @(negedge core_clk);
            chk("no_lock", 2'b00, {cfg_clk_out, cfg_data_oe});
            pll_locked = 1'b1;
         end
         if (md == 2'h3)
         begin
            repeat (4500) @(negedge core_clk);
            chk("busy_hold", 1'b0, load_done);
            consumer_busy = 1'b0;
         end
         for (n = 0; n < 6000 && load_done !== 1'b1; n = n + 1)
            @(negedge core_clk);
         chk("load_done", 1'b1, load_done);
         chk("load_ok", g, load_ok);
         chk("cfg_vec", ev, cfg_vec);
         link_sync_ok = 1'b0;
         repeat (20) @(negedge core_clk);
         chk("fault_lost", fexp(ev, 1'b0), link_fault_out);
         link_sync_ok = 1'b1;
         repeat (20) @(negedge core_clk);
         chk("fault_back", fexp(ev, 1'b1), link_fault_out);
         repeat (400) @(negedge core_clk);
         chk("cmds", {`SCL_BEGIN_CMD, `SCL_FINISH_CMD}, cmd_log);
         chk("idle", 2'b00, {cfg_clk_out, cfg_data_oe});
         #2;
         chk("ser", {ser_p_src, ser_n_src},
            {downstream_serial_out_p, downstream_serial_out_n});
      end
   endtask
   initial
   begin
      errors = 0;
      checks_done = 0;
      sd = $urandom(32'h92CD);
      repeat (2) @(negedge core_clk);
      srst = 1'b0;
      for (i = 0; i < 8; i = i + 1)
      begin
         v = {$urandom, $urandom};
         v[`SCL_FLT_MODE_LSB+:2] = i[1:0];
         v[`SCL_UP_EN_BIT] = (i != 5);
         run(v, (i == 4) ? `SCL_START_MARK ^ 8'h01 : `SCL_START_MARK,
            (i == 7) ? `SCL_END_MARK ^ 8'h80 : `SCL_END_MARK,
            (i == 1) ? 2'h3 : (i == 2) ? 2'h2 : (i == 6) ? 2'h1 : 2'h0);
      end
      tally_and_finish;
   end
   initial
   begin
      repeat (80000) @(posedge core_clk);
      errors = errors + 1;
      tally_and_finish;
   end
endmodule
bind scl_loader scl_loader_chk chk_u
(
   .core_clk, .srst, .ext_rst_n, .pll_locked, .cfg_clk_out,
   .cfg_data_in, .cfg_data_out, .cfg_data_oe, .consumer_busy,
   .cfg_vec, .load_done, .load_ok, .ser_p_src, .ser_n_src,
   .downstream_serial_out_p, .downstream_serial_out_n,
   .link_sync_ok, .link_fault_out
);
